// >>> hdl/pmw_pkg.sv
// power-mode / wake-up / watchdog package: register map, field positions, timing counts
// assumes a single 100 MHz system clock and a classic wishbone register bus
package pmw_pkg;

    // ****************************************************************
    // register map (word aligned byte addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_MODE = 4'h0;       // system_mode_register
    localparam logic [3:0] ADDR_WDOG = 4'h4;       // watchdog_control
    localparam logic [3:0] ADDR_STATUS = 4'h8;     // flags and current mode, read only
    localparam logic [3:0] ADDR_WAKE_EN = 4'hc;    // porta_wake_enable

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] MODE_RESET = 8'h03;     // idle_select=1, high_clock_select=1
    localparam logic [7:0] WDOG_RESET = 8'h7a;
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MODE_HCLK_BIT = 0;              // high_clock_select
    localparam int MODE_IDLE_BIT = 1;              // idle_select
    localparam int MODE_READY_BIT = 2;             // fast_osc_ready (read only)
    localparam int MODE_SLOW_READY_BIT = 3;        // slow oscillator ready (read only)
    localparam int MODE_DIV_LSB = 5;               // clock_divider_select [7:5]
    localparam int WDOG_KEEP_BIT = 7;              // idle_sysclk_keep
    localparam int WDOG_PER_LSB = 4;               // wdt_period_select [6:4]
    localparam int STAT_PDF_BIT = 0;               // powerdown_flag
    localparam int STAT_TO_BIT = 1;                // timeout_flag

    // ****************************************************************
    // timing counts
    // ****************************************************************
    localparam int WDT_BASE_LOG2 = 8;              // 256 slow cycles at select 000
    localparam int WDT_MAX_LOG2 = 15;              // 32768 slow cycles at select 111
    localparam logic [4:0] SST_FAST_CYCLES = 5'd16; // fast start-up, 15..16 cycles
    localparam logic [4:0] SST_SLOW_CYCLES = 5'd2;  // slow start-up, 1..2 cycles

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        PM_NORMAL,
        PM_SLOW,
        PM_SLEEP,
        PM_IDLE_OFF,
        PM_IDLE_ON,
        PM_START
    } pmw_mode_t;

    // halt / clear requests from the core
    typedef struct packed {
        logic halt;
        logic clear_watchdog_instr;
    } pmw_core_req_t;

    // clock gating outputs
    typedef struct packed {
        logic cpu_run;
        logic sys_clk_en;
        logic fast_osc_en;
        logic use_slow;
        logic tbc_en;
    } pmw_clk_ctl_t;

endpackage : pmw_pkg

// >>> hdl/pmw_wdog.sv
// watchdog counter clocked by slow oscillator ticks
// assumes slow_tick is already synchronised into the system clock domain
`timescale 1ns/10ps
`default_nettype none
module pmw_wdog
    import pmw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic slow_tick,
    input wire logic clear,
    input wire logic [2:0] period_sel,
    // result
    output logic overflow
);
    // ****************************************************************
    // counter
    // ****************************************************************
    logic [WDT_MAX_LOG2-1:0] cnt_q; // slow-cycle count
    logic [WDT_MAX_LOG2-1:0] limit; // last count before time-out

    // time-out after 2^(8+sel) slow cycles
    assign limit = WDT_MAX_LOG2'((32'd1 << (WDT_BASE_LOG2 + 32'(period_sel))) - 32'd1);

    // counts in every mode because the slow oscillator never stops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (clear) begin
                cnt_q <= '0;
            end else if (slow_tick) begin
                if (cnt_q >= limit) begin
                    cnt_q <= '0;
                    overflow <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule // pmw_wdog
`default_nettype wire

// >>> hdl/pmw_sst.sv
// start-up timer shared by both oscillators
// assumes ticks of the chosen oscillator arrive synchronised
`timescale 1ns/10ps
`default_nettype none
module pmw_sst
    import pmw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic [4:0] length,
    input wire logic osc_tick,
    // result
    output logic busy,
    output logic done
);
    // ****************************************************************
    // countdown
    // ****************************************************************
    logic [4:0] left_q; // oscillator cycles left

    // one counter serves both oscillators; only the length differs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_q <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                left_q <= length;
            end else if (left_q != 5'd0 && osc_tick) begin
                left_q <= left_q - 5'd1;
                done <= (left_q == 5'd1);
            end
        end
    end

    assign busy = (left_q != 5'd0);
endmodule // pmw_sst
`default_nettype wire

// >>> hdl/pmw_ctrl.sv
// power-mode controller: run mode select, halt modes, wake-up, watchdog, flags
// assumes oscillator ticks and port pins come from outside and are synchronised here,
// core halt / clear pulses are one cycle on REF_CLK
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl
    import pmw_pkg::*;
#(
    parameter int PORT_W = 8 // port A width
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // oscillators (asynchronous toggling clocks)
    input wire logic SLOW_OSC,
    input wire logic FAST_OSC,
    // core
    input wire pmw_pkg::pmw_core_req_t CORE_REQ,
    input wire logic IRQ_PENDING,
    input wire logic IRQ_ENABLED,
    input wire logic STACK_FULL,
    output var pmw_pkg::pmw_clk_ctl_t CLK_CTL,
    output logic IRQ_SERVICE,
    output logic WAKE_PULSE,
    output logic CORE_RESET,
    output logic PC_SP_RESET,
    // port A
    input wire logic [PORT_W-1:0] PORT_A,
    // mode
    output var pmw_pkg::pmw_mode_t MODE
);
    // ****************************************************************
    // synchronisers
    // ****************************************************************
    logic slow_s1_q, slow_s2_q; // slow oscillator, two stages
    logic fast_s1_q, fast_s2_q; // fast oscillator, two stages
    logic slow_prev_q, fast_prev_q; // for edge detect on stage2
    logic [PORT_W-1:0] pa_s1_q, pa_s2_q, pa_prev_q;
    logic slow_tick, fast_tick;

    // two flops before anything looks at a pin
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            slow_s1_q <= '0;
            slow_s2_q <= '0;
            fast_s1_q <= '0;
            fast_s2_q <= '0;
            slow_prev_q <= 1'b0;
            fast_prev_q <= 1'b0;
            pa_s1_q <= '1;
            pa_s2_q <= '1;
            pa_prev_q <= '1;
        end else begin
            slow_s1_q <= SLOW_OSC;
            slow_s2_q <= slow_s1_q;
            fast_s1_q <= FAST_OSC;
            fast_s2_q <= fast_s1_q;
            slow_prev_q <= slow_s2_q;
            fast_prev_q <= fast_s2_q;
            pa_s1_q <= PORT_A;
            pa_s2_q <= pa_s1_q;
            pa_prev_q <= pa_s2_q;
        end
    end
    // a tick is one rising edge seen after the second stage; an oscillator
    // faster than half of REF_CLK would lose ticks here
    assign slow_tick = slow_s2_q & ~slow_prev_q;
    assign fast_tick = fast_s2_q & ~fast_prev_q;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] mode_reg_q; // system_mode_register (writable bits)
    logic [7:0] wdog_q; // watchdog_control
    logic [PORT_W-1:0] wake_en_q; // porta_wake_enable
    logic pdf_q, to_q; // powerdown_flag, timeout_flag
    logic ready_q; // fast_osc_ready
    logic wr_stb;
    logic halt_go, wdt_ovf, irq_at_halt_q;
    pmw_mode_t mode_q;

    assign wr_stb = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];

    // software writes; bits 3..0 of watchdog control are plain storage
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode_reg_q <= MODE_RESET;
            wdog_q <= WDOG_RESET;
            wake_en_q <= PORT_W'(WAKE_EN_RESET);
        end else if (wr_stb) begin
            unique case (WB_ADR_I)
                ADDR_MODE: mode_reg_q <= WB_DAT_I[7:0] & 8'hf3; // bits 3..2 read-only
                ADDR_WDOG: wdog_q <= WB_DAT_I[7:0];
                ADDR_WAKE_EN: wake_en_q <= WB_DAT_I[PORT_W-1:0];
                default: ;
            endcase
        end
    end

    // read mux, one-cycle answer, ack drops the cycle after
    function automatic logic [31:0] rd_word(input logic [3:0] a);
        logic [31:0] r;
        r = '0;
        unique case (a)
            ADDR_MODE: r[7:0] = mode_reg_q | {4'h0, 1'b1, ready_q, 2'b00};
            ADDR_WDOG: r[7:0] = wdog_q;
            ADDR_STATUS: r[7:0] = {3'h0, 2'b00, 1'b0, to_q, pdf_q} | {mode_q, 5'h00};
            ADDR_WAKE_EN: r[PORT_W-1:0] = wake_en_q;
            default: r = '0; // unmapped reads as zero
        endcase
        return r;
    endfunction

    // bus answer; unmapped addresses still acked
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
            if (WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_WE_I) begin
                WB_DAT_O <= rd_word(WB_ADR_I);
            end
        end
    end

    // ****************************************************************
    // run mode selection
    // ****************************************************************
    logic want_slow;
    logic [2:0] div_sel;
    assign div_sel = mode_reg_q[MODE_DIV_LSB +: 3];
    // low select with divider 000/001 runs from slow osc else fast
    assign want_slow = ~mode_reg_q[MODE_HCLK_BIT] & (div_sel[2:1] == 2'b00);

    // ****************************************************************
    // watchdog and start-up timer
    // ****************************************************************
    logic wdt_clear;
    logic sst_start, sst_busy, sst_done;
    logic [4:0] sst_len;
    logic sst_tick;

    // halt and clear instruction both clear the counter
    assign wdt_clear = CORE_REQ.clear_watchdog_instr | halt_go;

    // watchdog on slow osc, runs in every mode
    pmw_wdog u_wdog (
        .clk(REF_CLK),
        .rst(RST),
        .slow_tick(slow_tick),
        .clear(wdt_clear),
        .period_sel(wdog_q[WDOG_PER_LSB +: 3]),
        .overflow(wdt_ovf)
    );

    // shared start timer, length by target oscillator
    assign sst_tick = want_slow ? slow_tick : fast_tick;
    assign sst_len = want_slow ? SST_SLOW_CYCLES : SST_FAST_CYCLES;
    pmw_sst u_sst (
        .clk(REF_CLK),
        .rst(RST),
        .start(sst_start),
        .length(sst_len),
        .osc_tick(sst_tick),
        .busy(sst_busy),
        .done(sst_done)
    );

    // ****************************************************************
    // mode state machine
    // ****************************************************************
    logic low_power, port_wake, irq_wake, wake;
    assign low_power = (mode_q == PM_SLEEP) | (mode_q == PM_IDLE_OFF) | (mode_q == PM_IDLE_ON);
    assign halt_go = CORE_REQ.halt & ((mode_q == PM_NORMAL) | (mode_q == PM_SLOW));
    // falling edge on an enabled pin
    assign port_wake = |(wake_en_q & pa_prev_q & ~pa_s2_q);
    // an irq already pending at halt cannot wake
    assign irq_wake = IRQ_PENDING & ~irq_at_halt_q;
    assign wake = low_power & (port_wake | irq_wake | wdt_ovf);

    // remember whether an irq was pending when halting
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_at_halt_q <= 1'b0;
        end else if (halt_go) begin
            irq_at_halt_q <= IRQ_PENDING;
        end else if (!IRQ_PENDING) begin
            irq_at_halt_q <= 1'b0;
        end
    end

    // mode sequencing; external reset wake is RST itself
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode_q <= PM_NORMAL;
        end else begin
            unique case (mode_q)
                PM_NORMAL, PM_SLOW: begin
                    if (halt_go) begin
                        if (!mode_reg_q[MODE_IDLE_BIT]) mode_q <= PM_SLEEP;
                        else if (!wdog_q[WDOG_KEEP_BIT]) mode_q <= PM_IDLE_OFF;
                        else mode_q <= PM_IDLE_ON;
                    end else begin
                        mode_q <= want_slow ? PM_SLOW : PM_NORMAL;
                    end
                end
                PM_SLEEP, PM_IDLE_OFF, PM_IDLE_ON: begin
                    if (wake) mode_q <= PM_START;
                end
                PM_START: begin
                    // no instruction until oscillator stable
                    if (sst_done) mode_q <= want_slow ? PM_SLOW : PM_NORMAL;
                end
            endcase
        end
    end
    assign sst_start = wake | (~want_slow & (mode_q == PM_SLOW)); // restart on fast switch
    assign MODE = mode_q;

    // fast_osc_ready: low in sleep/idle off, set by start timer
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ready_q <= 1'b0;
        end else if (halt_go & ~(mode_reg_q[MODE_IDLE_BIT] & wdog_q[WDOG_KEEP_BIT])) begin
            ready_q <= 1'b0;
        end else if (sst_start & ~want_slow) begin
            ready_q <= 1'b0;
        end else if (sst_done | (~sst_busy & ~low_power & mode_q != PM_START)) begin
            ready_q <= 1'b1;
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // pdf: set by halt, cleared by clear instr; to: cleared by halt, set by time-out
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pdf_q <= 1'b0;
            to_q <= 1'b0;
        end else begin
            if (halt_go) pdf_q <= 1'b1;
            else if (CORE_REQ.clear_watchdog_instr) pdf_q <= 1'b0;
            if (wdt_ovf) to_q <= 1'b1;
            else if (halt_go) to_q <= 1'b0;
        end
    end

    // ****************************************************************
    // core side outputs
    // ****************************************************************
    // reset and wake pulses to the core; state kept in low power
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            CORE_RESET <= 1'b0;
            PC_SP_RESET <= 1'b0;
            WAKE_PULSE <= 1'b0;
            IRQ_SERVICE <= 1'b0;
        end else begin
            CORE_RESET <= wdt_ovf & ~low_power & (mode_q != PM_START);
            PC_SP_RESET <= wdt_ovf & low_power;
            WAKE_PULSE <= (mode_q == PM_START) & sst_done;
            // regular response only if enabled with free stack
            IRQ_SERVICE <= (mode_q == PM_START) & sst_done & IRQ_PENDING
                & IRQ_ENABLED & ~STACK_FULL;
        end
    end

    // clock gating per mode
    always_comb begin
        CLK_CTL.cpu_run = (mode_q == PM_NORMAL) | (mode_q == PM_SLOW);
        CLK_CTL.sys_clk_en = CLK_CTL.cpu_run | (mode_q == PM_IDLE_ON) | (mode_q == PM_START);
        CLK_CTL.fast_osc_en = ~want_slow & (mode_q != PM_SLEEP) & (mode_q != PM_IDLE_OFF);
        CLK_CTL.use_slow = want_slow;
        CLK_CTL.tbc_en = (mode_q != PM_SLEEP);
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sleep_entry_a: assert property (@(posedge REF_CLK) disable iff (RST)
        halt_go & ~mode_reg_q[MODE_IDLE_BIT] |=> mode_q == PM_SLEEP)
        else $error("halt with idle clear did not sleep");
    idle_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
        halt_go & mode_reg_q[MODE_IDLE_BIT] & ~wdog_q[WDOG_KEEP_BIT] |=> mode_q == PM_IDLE_OFF)
        else $error("idle off not entered");
    idle_on_a: assert property (@(posedge REF_CLK) disable iff (RST)
        halt_go & mode_reg_q[MODE_IDLE_BIT] & wdog_q[WDOG_KEEP_BIT] |=> mode_q == PM_IDLE_ON)
        else $error("idle on not entered");
    halt_flags_a: assert property (@(posedge REF_CLK) disable iff (RST)
        halt_go & ~wdt_ovf |=> pdf_q & ~to_q)
        else $error("halt flags wrong");
    pdf_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CORE_REQ.clear_watchdog_instr & ~halt_go |=> ~pdf_q)
        else $error("powerdown flag not cleared");
    timeout_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
        wdt_ovf & low_power |=> to_q & PC_SP_RESET)
        else $error("watchdog wake missing");
    slow_select_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (mode_q == PM_NORMAL) & want_slow & ~halt_go |=> mode_q == PM_SLOW)
        else $error("slow mode not entered");
    ready_low_a: assert property (@(posedge REF_CLK) disable iff (RST)
        mode_q == PM_SLEEP |-> ~ready_q)
        else $error("ready high in sleep");
    stale_irq_a: assert property (@(posedge REF_CLK) disable iff (RST)
        low_power & irq_at_halt_q & ~port_wake & ~wdt_ovf |=> mode_q != PM_START)
        else $error("stale irq woke device");
endmodule // pmw_ctrl
`default_nettype wire

// >>> tb/pmw_core_model.sv
// partner model: processor core pulses and the two free-running oscillators
// assumes the bench calls pulse() right after a rising REF_CLK edge
`timescale 1ns/10ps
`default_nettype none
module pmw_core_model
    import pmw_pkg::*;
(
    // clock
    input wire logic clk,
    // core and oscillators
    output var pmw_pkg::pmw_core_req_t core_req,
    output logic slow_osc,
    output logic fast_osc
);
    // quiet start, no request at time zero
    initial begin
        core_req = '0;
        slow_osc = 1'b0;
        fast_osc = 1'b0;
    end
    // oscillators never stop; phase unrelated to REF_CLK
    always #30 slow_osc = ~slow_osc;
    always #11 fast_osc = ~fast_osc;
    // one-cycle pulse: halt when set, else clear-watchdog
    task automatic pulse(input logic halt);
        @(posedge clk);
        core_req <= halt ? 2'b10 : 2'b01;
        @(posedge clk);
        core_req <= '0;
    endtask
endmodule // pmw_core_model
`default_nettype wire

// >>> tb/test_pmw_ctrl.sv
// testbench: registers, run modes, halt modes, wake-up sources and watchdog
// assumes pmw_core_model stands in for the core; all tasks return just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module test_pmw_ctrl;
    import pmw_pkg::*;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq_p = 1'b0, irq_e = 1'b1, stk = 1'b0, svc, wake, crst, pcsp, slow, fast;
    logic [7:0] port = 8'hff; // pins idle high through pull-ups
    logic [7:0] q; // last read byte
    logic [3:0] sel = 4'h0; // byte lanes of the current request
    logic [2:0] pulses; // {pc/sp reset, core reset, wake} for bounded waits
    pmw_core_req_t req;
    pmw_clk_ctl_t cctl;
    pmw_mode_t mode;
    int bad_count = 0, checks_done = 0, slow_edges = 0;
    always #5 clk = ~clk;
    always @(posedge slow) slow_edges++;
    assign pulses = {pcsp, crst, wake};
    pmw_core_model core_u (.clk(clk), .core_req(req), .slow_osc(slow), .fast_osc(fast));
    pmw_ctrl dut_u (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SLOW_OSC(slow), .FAST_OSC(fast), .CORE_REQ(req), .IRQ_PENDING(irq_p),
        .IRQ_ENABLED(irq_e), .STACK_FULL(stk), .CLK_CTL(cctl), .IRQ_SERVICE(svc),
        .WAKE_PULSE(wake), .CORE_RESET(crst), .PC_SP_RESET(pcsp), .PORT_A(port), .MODE(mode));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] s = 4'h1);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n >= 20) chk("bus ack", 1, 0);
    endtask
    // bounded wait for a design pulse
    task automatic wait_hi(input int b, input int lim, input string what);
        for (int n = 0; n < lim && pulses[b] !== 1'b1; n++) @(posedge clk);
        chk(what, 1, pulses[b]);
    endtask
    task automatic wait_mode(input pmw_mode_t m, input string what);
        for (int n = 0; n < 80 && mode !== m; n++) @(posedge clk);
        chk(what, m, mode);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        wb(0, ADDR_WDOG, 0);
        chk("wdog reset", WDOG_RESET, q);
        wb(1, ADDR_WDOG, 8'h05); // shortest period, loose bits 0101
        core_u.pulse(0);
        wb(1, ADDR_WDOG, 8'hff, 4'h0); // lane 0 off, must be ignored
        wb(0, ADDR_WDOG, 0);
        chk("wdog loose bits", 8'h05, q);
        wb(0, 4'h2, 0);
        chk("unmapped read", 0, q);
        $display("test regs done");
    endtask
    task automatic t_clock;
        wb(1, ADDR_MODE, 8'h02); // low select, divider 000
        wait_mode(PM_SLOW, "slow mode");
        chk("slow source", 1, cctl.use_slow);
        wb(1, ADDR_MODE, 8'h42); // divider 010
        wait_mode(PM_NORMAL, "normal mode");
        wb(0, ADDR_MODE, 0);
        chk("ready low on switch", 0, q[MODE_READY_BIT]);
        for (int n = 0; n < 30 && q[MODE_READY_BIT] !== 1'b1; n++) wb(0, ADDR_MODE, 0);
        chk("fast ready", 1, q[MODE_READY_BIT]);
        $display("test clock done");
    endtask
    // each halt mode, woken by an enabled port pin
    task automatic t_halt;
        logic [2:0] m_exp;
        logic [4:0] c_exp;
        wb(1, ADDR_WAKE_EN, 8'h01);
        for (int k = 0; k < 3; k++) begin
            wb(1, ADDR_MODE, k == 0 ? 8'h01 : 8'h03);
            wb(1, ADDR_WDOG, k == 2 ? 8'h85 : 8'h05);
            core_u.pulse(1);
            @(posedge clk);
            m_exp = k == 0 ? PM_SLEEP : k == 1 ? PM_IDLE_OFF : PM_IDLE_ON;
            c_exp = k == 0 ? 5'h00 : k == 1 ? 5'h01 : 5'h0d; // {cpu, sys, fast, slow, tbc}
            chk("halt mode", m_exp, mode);
            chk("halt clocks", c_exp, cctl);
            wb(0, ADDR_STATUS, 0);
            chk("halt flags", 2'b01, q[1:0]);
            wb(0, ADDR_MODE, 0);
            if (k < 2) chk("ready low", 0, q[MODE_READY_BIT]);
            port <= 8'hfe;
            wait_hi(0, 80, "port wake");
            chk("port no service", 0, svc);
            port <= 8'hff;
            wait_mode(PM_NORMAL, "back to run");
            chk("run clocks", 5'h1d, cctl);
            wb(0, ADDR_MODE, 0);
            chk("ready after wake", 1, q[MODE_READY_BIT]);
            core_u.pulse(0);
            wb(0, ADDR_STATUS, 0);
            chk("pdf cleared", 0, q[STAT_PDF_BIT]);
        end
        $display("test halt done");
    endtask
    // pending flag before halt, then serviced and deferred interrupt wakes
    task automatic t_irq;
        wb(1, ADDR_MODE, 8'h01);
        irq_p <= 1'b1;
        core_u.pulse(1);
        repeat (40) @(posedge clk);
        chk("pending no wake", PM_SLEEP, mode);
        // serviced, then stack full, then interrupt disabled
        for (int k = 0; k < 3; k++) begin
            irq_p <= 1'b0;
            stk <= (k == 1);
            irq_e <= (k != 2);
            if (k > 0) core_u.pulse(1);
            @(posedge clk);
            irq_p <= 1'b1;
            wait_hi(0, 80, "irq wake");
            chk("irq service", k == 0, svc);
        end
        irq_p <= 1'b0;
        stk <= 1'b0;
        irq_e <= 1'b1;
        $display("test irq done");
    endtask
    task automatic t_wdog;
        core_u.pulse(0);
        slow_edges = 0;
        wait_hi(1, 2500, "run time-out");
        chk("time-out span", 1, slow_edges >= 254 && slow_edges <= 259);
        wb(1, ADDR_MODE, 8'h01);
        wb(1, ADDR_WDOG, 8'h05);
        wb(0, ADDR_STATUS, 0);
        chk("to after reset", 1, q[STAT_TO_BIT]);
        core_u.pulse(1);
        wait_hi(2, 2500, "sleep time-out");
        wb(0, ADDR_STATUS, 0);
        chk("sleep time-out flags", 2'b11, q[1:0]);
        $display("test wdog done");
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_clock();
        t_halt();
        t_irq();
        t_wdog();
        stop_test();
    end
    initial begin
        #300000;
        bad_count++;
        stop_test();
    end
endmodule // test_pmw_ctrl
`default_nettype wire
